// ===== hdl/lsas_map.vh
// Offsets, field positions, masks and reset values of the legacy segment steering block
`ifndef LSAS_MAP_VH
`define LSAS_MAP_VH

// Attribute register offsets on the configuration port
`define LSAS_OFS_ATTR0 8'h90
`define LSAS_OFS_ATTR1 8'h91
`define LSAS_OFS_ATTR2 8'h92
`define LSAS_OFS_ATTR3 8'h93
`define LSAS_OFS_ATTR4 8'h94
`define LSAS_OFS_ATTR5 8'h95
`define LSAS_OFS_ATTR6 8'h96
`define LSAS_NUM_ATTR 7

// Reset value of every attribute register
`define LSAS_ATTR_RESET 8'h00

// Writable bit masks; all other bits are reserved
`define LSAS_MASK_TOP 8'h30
`define LSAS_MASK_PAIR 8'h33

// Field positions inside an attribute register
`define LSAS_UPPER_LSB 4
`define LSAS_LOWER_LSB 0
`define LSAS_READ_BIT 0
`define LSAS_WRITE_BIT 1

// Legacy window: address bits 19:18 = 2'b11 covers 0c0000-0fffff
`define LSAS_ADDR_W 32
`define LSAS_WIN_TAG 2'h3
`define LSAS_SEG_MSB 17
`define LSAS_SEG_LSB 14
`define LSAS_TOP_SEG_FIRST 4'hc

`endif

// ===== hdl/lsas_seg_decode.v
// Address to segment decoder returning the two steering bits for one cycle
`timescale 1ns/1ps
`include "lsas_map.vh"

module lsas_seg_decode (
    input wire [`LSAS_ADDR_W-1:0] addr, // Cycle address
    input wire [55:0] attr_flat, // Seven attribute registers, register 0 lowest
    output reg in_window, // Address is in 0c0000-0fffff
    output reg read_steer_bit, // Reads of this segment go to DRAM
    output reg write_steer_bit // Writes of this segment go to DRAM
);

    function [1:0] pick_field;
        input [55:0] regs;
        input [3:0] seg;
        reg [2:0] idx;
        reg [7:0] r;
        begin
            idx = 3'h0;
            r = 8'h00;
            if (seg >= `LSAS_TOP_SEG_FIRST) begin
                // The top 64 KB is one segment in the upper field of register 0
                r = regs[7:0];
                pick_field = r[`LSAS_UPPER_LSB+1:`LSAS_UPPER_LSB];
            end else begin
                idx = 3'h1 + {1'b0, seg[2:1]} + {seg[3], 2'h0};
                r = regs[idx*8 +: 8];
                if (seg[0])
                    pick_field = r[`LSAS_UPPER_LSB+1:`LSAS_UPPER_LSB];
                else
                    pick_field = r[`LSAS_LOWER_LSB+1:`LSAS_LOWER_LSB];
            end
        end
    endfunction

    reg [1:0] field;

    always @* begin
        in_window = (addr[`LSAS_ADDR_W-1:20] == 12'h000) && (addr[19:18] == `LSAS_WIN_TAG);
        field = pick_field(attr_flat, addr[`LSAS_SEG_MSB:`LSAS_SEG_LSB]);
        read_steer_bit = in_window & field[`LSAS_READ_BIT];
        write_steer_bit = in_window & field[`LSAS_WRITE_BIT];
    end

endmodule // lsas_seg_decode

// ===== hdl/lsas_steer.v
// Legacy segment attribute registers and read/write steering for host and downstream cycles
// Operation
// - Steer thirteen segments from 768 KB to 1 MB
// - Seven byte registers, two-bit field per region
// - Attributes apply to host and downstream cycles
// - Read bit set sends reads to DRAM
// - Write bit set sends writes to DRAM
// - Top register bits 5:4 steer 0f0000-0fffff
// - Registers reset to zero, everything to link
// - Downstream access to disabled segment is illegal
// - Next register bits 1:0 steer 0c0000-0c3fff
`timescale 1ns/1ps
`include "lsas_map.vh"

module lsas_steer (
    input wire clk, // Core clock, 25 MHz
    input wire rst, // Synchronous reset, active high
    input wire ce, // Clock enable; low freezes all state
    input wire [7:0] cfg_addr, // Configuration byte offset
    input wire cfg_wr, // Configuration write strobe
    input wire cfg_rd, // Configuration read strobe
    input wire [7:0] cfg_wdata, // Configuration write data
    output wire [7:0] cfg_rdata, // Read data, valid the cycle after cfg_rd
    output wire cfg_rvalid, // Read data valid pulse
    input wire host_valid, // Host cycle presented
    input wire [`LSAS_ADDR_W-1:0] host_addr, // Host cycle address
    input wire host_write, // Host cycle is a write
    output wire host_to_dram, // Host cycle claimed for main memory
    output wire host_to_link, // Host legacy cycle forwarded to the south link
    input wire dn_valid, // Downstream cycle presented
    input wire [`LSAS_ADDR_W-1:0] dn_addr, // Downstream cycle address
    input wire dn_write, // Downstream cycle is a write
    output wire dn_to_dram, // Downstream cycle claimed for main memory
    output wire dn_to_link, // Downstream legacy cycle sent back to the link
    output wire dn_illegal // Downstream cycle hit a segment not fully enabled
);

    reg [7:0] attr_q [0:`LSAS_NUM_ATTR-1];
    reg [7:0] attr_d [0:`LSAS_NUM_ATTR-1];
    reg [7:0] rdata_q;
    reg [7:0] rdata_d;
    reg rvalid_q;
    reg rvalid_d;
    reg [2:0] wr_idx;
    reg wr_hit;
    reg wr_take;
    reg [7:0] wr_val;
    reg [2:0] rd_idx;
    reg rd_hit;
    reg rd_take;
    reg host_dram_c;
    reg host_link_c;
    reg dn_dram_c;
    reg dn_link_c;
    reg dn_bad_c;
    reg [55:0] attr_flat;
    wire host_win;
    wire host_re;
    wire host_we;
    wire host_claim;
    wire dn_win;
    wire dn_re;
    wire dn_we;
    wire dn_claim;
    integer i;
    integer k;
    integer j;

    // Offset to register index; also reports whether the offset is mapped
    function [3:0] offset_index;
        input [7:0] ofs;
        begin
            case (ofs)
                `LSAS_OFS_ATTR0: offset_index = 4'h8;
                `LSAS_OFS_ATTR1: offset_index = 4'h9;
                `LSAS_OFS_ATTR2: offset_index = 4'ha;
                `LSAS_OFS_ATTR3: offset_index = 4'hb;
                `LSAS_OFS_ATTR4: offset_index = 4'hc;
                `LSAS_OFS_ATTR5: offset_index = 4'hd;
                `LSAS_OFS_ATTR6: offset_index = 4'he;
                default: offset_index = 4'h0;
            endcase
        end
    endfunction

    // Register 0 has only the upper field; the others carry two
    function [7:0] write_mask;
        input [2:0] idx;
        begin
            if (idx == 3'h0)
                write_mask = `LSAS_MASK_TOP;
            else
                write_mask = `LSAS_MASK_PAIR;
        end
    endfunction

    // Picks the steering bit that matches the cycle direction
    function steer_pick;
        input is_write;
        input re_bit;
        input we_bit;
        begin
            if (is_write)
                steer_pick = we_bit;
            else
                steer_pick = re_bit;
        end
    endfunction

    always @* begin
        {wr_hit, wr_idx} = offset_index(cfg_addr);
        {rd_hit, rd_idx} = offset_index(cfg_addr);
        wr_take = cfg_wr & wr_hit;
        rd_take = cfg_rd;
        wr_val = cfg_wdata & write_mask(wr_idx);
    end

    // Only the addressed register moves; unmapped offsets change nothing
    always @* begin
        for (k = 0; k < `LSAS_NUM_ATTR; k = k + 1) begin
            attr_d[k] = attr_q[k];
        end
        if (wr_take)
            attr_d[wr_idx] = wr_val;
    end

    // Read data holds between reads so a late sampler still sees it
    always @* begin
        rdata_d = rdata_q;
        rvalid_d = rd_take;
        if (rd_take) begin
            if (rd_hit)
                rdata_d = attr_q[rd_idx] & write_mask(rd_idx);
            else
                rdata_d = 8'h00;
        end
    end

    // Reset obeys the clock enable too, so a frozen block stays frozen
    always @(posedge clk) begin
        if (ce) begin
            if (rst) begin
                for (i = 0; i < `LSAS_NUM_ATTR; i = i + 1)
                    attr_q[i] <= `LSAS_ATTR_RESET;
                rdata_q <= 8'h00;
                rvalid_q <= 1'b0;
            end else begin
                for (i = 0; i < `LSAS_NUM_ATTR; i = i + 1)
                    attr_q[i] <= attr_d[i];
                rdata_q <= rdata_d;
                rvalid_q <= rvalid_d;
            end
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_rvalid = rvalid_q;

    // Flattened view for the two decoders, register 0 in the low byte
    always @* begin
        for (j = 0; j < `LSAS_NUM_ATTR; j = j + 1) begin
            attr_flat[j*8 +: 8] = attr_q[j];
        end
    end

    lsas_seg_decode u_host_dec (
        .addr(host_addr),
        .attr_flat(attr_flat),
        .in_window(host_win),
        .read_steer_bit(host_re),
        .write_steer_bit(host_we)
    );

    lsas_seg_decode u_dn_dec (
        .addr(dn_addr),
        .attr_flat(attr_flat),
        .in_window(dn_win),
        .read_steer_bit(dn_re),
        .write_steer_bit(dn_we)
    );

    // Combinational so the claim is known in the cycle the address shows up
    assign host_claim = steer_pick(host_write, host_re, host_we);
    assign dn_claim = steer_pick(dn_write, dn_re, dn_we);

    // Cycles outside the legacy window are not ours to steer
    always @* begin
        host_dram_c = 1'b0;
        host_link_c = 1'b0;
        if (host_valid && host_win) begin
            if (host_claim)
                host_dram_c = 1'b1;
            else
                host_link_c = 1'b1;
        end
    end

    // Such a cycle may stall the real bridge; here it is only flagged
    always @* begin
        dn_dram_c = 1'b0;
        dn_link_c = 1'b0;
        dn_bad_c = 1'b0;
        if (dn_valid && dn_win) begin
            if (dn_claim)
                dn_dram_c = 1'b1;
            else
                dn_link_c = 1'b1;
            dn_bad_c = ~(dn_re & dn_we);
        end
    end

    assign host_to_dram = host_dram_c;
    assign host_to_link = host_link_c;
    assign dn_to_dram = dn_dram_c;
    assign dn_to_link = dn_link_c;
    assign dn_illegal = dn_bad_c;

endmodule // lsas_steer

// ===== test/lsas_steer_checker.sv
// Port-level assertions for the legacy segment steering block
`timescale 1ns/1ps
module lsas_steer_checker (
    input wire clk, rst, ce, cfg_wr, cfg_rd, cfg_rvalid, host_valid, host_write, host_to_dram, host_to_link,
    input wire dn_valid, dn_write, dn_to_dram, dn_to_link, dn_illegal,
    input wire [7:0] cfg_addr, cfg_wdata, cfg_rdata,
    input wire [31:0] host_addr, dn_addr
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
property p_rv; ce && cfg_rd |=> cfg_rvalid; endproperty
a_rv: assert property (p_rv) else $error("no rvalid");
property p_rs; ce && cfg_rd && cfg_addr == 8'h90 |=> cfg_rdata[7:6] == 2'h0 && cfg_rdata[3:0] == 4'h0; endproperty
a_rs: assert property (p_rs) else $error("reserved bits set");
property p_wb; ce && cfg_wr && cfg_addr == 8'h90 ##1 !cfg_wr ##1 ce && cfg_rd && !cfg_wr && cfg_addr == 8'h90
    |=> cfg_rdata == {2'h0, $past(cfg_wdata[5:4], 3), 4'h0}; endproperty
a_wb: assert property (p_wb) else $error("top field lost");
property p_ou; host_valid && host_addr[31:18] != 14'h3 |-> !host_to_dram && !host_to_link; endproperty
a_ou: assert property (p_ou) else $error("steer outside window");
property p_ex; host_valid && host_addr[31:18] == 14'h3 |-> host_to_dram != host_to_link; endproperty
a_ex: assert property (p_ex) else $error("steer not exclusive");
property p_il; dn_valid && dn_to_link |-> dn_illegal; endproperty
a_il: assert property (p_il) else $error("illegal not flagged");
property p_sm; host_valid && dn_valid && host_addr == dn_addr && host_write == dn_write |-> host_to_dram == dn_to_dram;
endproperty
a_sm: assert property (p_sm) else $error("host and dn differ");
property p_iv; !host_valid && !dn_valid |-> !host_to_dram && !host_to_link && !dn_to_dram && !dn_to_link && !dn_illegal;
endproperty
a_iv: assert property (p_iv) else $error("steer without cycle");
property p_rt; disable iff (1'b0) rst && ce |=> cfg_rdata == 8'h00 && !cfg_rvalid; endproperty
a_rt: assert property (p_rt) else $error("reset state wrong");
endmodule // lsas_steer_checker
bind lsas_steer lsas_steer_checker chk (.*);

// ===== test/lsas_initiator.sv
// Host or downstream initiator presenting one cycle per request
`timescale 1ns/1ps
module lsas_initiator (input wire clk, input wire en, input wire [31:0] a, input wire w,
    output reg v = 0, output reg [31:0] addr = 0, output reg wr = 0);
always @(posedge clk) begin
    v <= en;
    // Idle lines toggle so a stale address never looks valid
    addr <= en ? a : ~addr;
    wr <= en ? w : ~wr;
end
endmodule // lsas_initiator

// ===== test/tb_top.sv
// Self-checking bench for the legacy segment steering block
`timescale 1ns/1ps
module tb_top;
reg clk = 0, rst = 1, ce = 1, cfg_wr = 0, cfg_rd = 0, en = 0, cw_w = 0;
reg [7:0] cfg_addr = 0, cfg_wdata = 0;
reg [31:0] ca = 0, lf = 32'h382ab6ce;
wire [7:0] cfg_rdata;
wire cfg_rvalid, hv, hw, dv, dw, h_d, h_l, d_d, d_l, d_i;
wire [31:0] ha, da;
reg [7:0] m [0:6];
reg [7:0] q[$], s[$];
integer errors = 0, compares = 0, n = 0, i, r;
always #20 clk = ~clk;
lsas_initiator host (.clk(clk), .en(en), .a(ca), .w(cw_w), .v(hv), .addr(ha), .wr(hw));
lsas_initiator dn (.clk(clk), .en(en), .a(ca), .w(cw_w), .v(dv), .addr(da), .wr(dw));
lsas_steer dut (.clk(clk), .rst(rst), .ce(ce), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .host_valid(hv), .host_addr(ha),
    .host_write(hw), .host_to_dram(h_d), .host_to_link(h_l), .dn_valid(dv), .dn_addr(da), .dn_write(dw),
    .dn_to_dram(d_d), .dn_to_link(d_l), .dn_illegal(d_i));
function [31:0] nx(input [31:0] x); nx = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]}; endfunction
function [7:0] f(input [31:0] a, input w);
    reg [1:0] fl;
    begin
        fl = a[17:16] == 2'h3 ? m[0][5:4] : a[14] ? m[1 + a[17:15]][5:4] : m[1 + a[17:15]][1:0];
        f = a[31:18] != 14'h3 ? 8'h00 : {3'h0, fl[w], !fl[w], fl[w], !fl[w], fl != 2'h3};
    end
endfunction
task chk(input [7:0] e, input [7:0] g); begin
    compares = compares + 1;
    if (g !== e) begin errors = errors + 1; $display("ERROR %0t got %h exp %h", $time, g, e); end
end endtask
task report_and_stop; begin
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
end endtask
task cw(input [7:0] a, input [7:0] d, input e); begin
    @(posedge clk); cfg_wr <= 1; cfg_addr <= a; cfg_wdata <= d; ce <= e;
    @(posedge clk); cfg_wr <= 0; ce <= 1;
    if (e && a < 8'h97) m[a - 8'h90] = d & (a == 8'h90 ? 8'h30 : 8'h33);
end endtask
task cr(input [7:0] a); begin
    @(posedge clk); cfg_rd <= 1; cfg_addr <= a; q.push_back(a < 8'h97 ? m[a - 8'h90] : 8'h00);
    @(posedge clk); cfg_rd <= 0;
end endtask
task cyc(input [31:0] a, input w); begin
    @(posedge clk); en <= 1; ca <= a; cw_w <= w; s.push_back(f(a, w));
    @(posedge clk); en <= 0;
end endtask
always @(negedge clk) begin
    if (cfg_rvalid) chk(q.size() ? q.pop_front() : 8'hxx, cfg_rdata);
    if (hv) chk(s.size() ? s.pop_front() : 8'hxx, {3'h0, h_d, h_l, d_d, d_l, d_i});
end
always @(posedge clk) begin
    n <= n + 1;
    if (n == 5000) begin errors = errors + 1; report_and_stop; end
end
initial begin
    for (i = 0; i < 7; i = i + 1) m[i] = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 8; i = i + 1) cr(8'h90 + i[7:0]);
    // Every field code on every register; unprogrammed segments are illegal for downstream
    for (r = 0; r < 16; r = r + 1) begin
        for (i = 0; i < 8; i = i + 1) begin
            lf = nx(lf);
            cw(8'h90 + i[7:0], {lf[7:6], r[1:0], lf[3:2], r[3:2]}, 1'b1);
            cr(8'h90 + i[7:0]);
        end
        for (i = 0; i < 12; i = i + 1) begin
            lf = nx(lf);
            cyc(i == 0 ? {16'h000f, lf[15:0]} : i == 1 ? {18'h30, lf[13:0]} : lf[30] ? {14'h3, lf[17:0]} : lf,
                lf[22]);
        end
    end
    cw(8'h90, 8'h00, 1'b0);
    cr(8'h90);
    // Reset while the clock enable is low must not clear anything
    cw(8'h90, 8'h5f, 1'b1);
    @(posedge clk);
    rst <= 1;
    ce <= 0;
    @(posedge clk);
    rst <= 0;
    ce <= 1;
    cr(8'h90);
    repeat (2) @(posedge clk);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    for (i = 0; i < 7; i = i + 1) m[i] = 8'h00;
    cr(8'h90);
    cyc(32'h000f8000, 1'b1);
    repeat (3) @(posedge clk);
    report_and_stop;
end
endmodule // tb_top
